// File: sim/gmdc_keypad_model.sv
// Front panel keypad model
`timescale 1ns/1ps
`default_nettype none
module gmdc_keypad_model
(
   input wire logic i_clk,
   output logic o_key_view,
   output logic o_key_valve
);
   // Hold time gives a quick or a slow finger
   task automatic press(input bit valve, input int hold);
      @(posedge i_clk);
      #10;
      if (valve)
         o_key_valve = 1'b1;
      else
         o_key_view = 1'b1;
      repeat (hold) @(posedge i_clk);
      #10;
      o_key_view = 1'b0;
      o_key_valve = 1'b0;
      // Key seen low before any next press
      repeat (2) @(posedge i_clk);
      #10;
   endtask
   initial
   begin
      o_key_view = 1'b0;
      o_key_valve = 1'b0;
   end
endmodule
`default_nettype wire

// File: sim/gmdc_top_assertions.sv
// Concurrent checks on the ports of the gauge mode display controller
`timescale 1ns/1ps
`default_nettype none
module gmdc_top_checker
(
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_key_view,
   input wire logic i_key_valve,
   input wire logic i_ctrl_board,
   input wire logic i_valve_sel,
   input wire logic [2:0] i_valve_pos,
   input wire logic [2:0] o_mode,
   input wire logic o_valve_mode,
   input wire logic [2:0] o_valve_pos,
   input wire logic [gmdc_pkg::LEG_W-1:0] o_legends,
   input wire logic [gmdc_pkg::FIELD_W-1:0] o_main_field,
   input wire logic o_auto_drive
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_reset_n);
   // ****
   // Properties
   // ****
   property p_lamp;
      o_mode == 3'h0 |-> o_legends == '1 && o_main_field == '1;
   endproperty
   a_lamp: assert property (p_lamp) else $error("lamp test not full");
   property p_view_gen;
      $rose(i_key_view) && o_mode == 3'h1 |=> o_mode == 3'h2;
   endproperty
   a_view_gen: assert property (p_view_gen) else $error("no step to leakage");
   property p_view_wrap;
      $rose(i_key_view) && o_mode == 3'h4 |=> o_mode == 3'h1;
   endproperty
   a_view_wrap: assert property (p_view_wrap) else $error("no wrap");
   property p_view_skip;
      $rose(i_key_view) && o_mode == 3'h2 && !i_ctrl_board |=> o_mode == 3'h4;
   endproperty
   a_view_skip: assert property (p_view_skip) else $error("tuning not skipped");
   property p_valve_tog;
      $rose(i_key_valve) && o_mode != 3'h0 && i_ctrl_board |=> o_valve_mode != $past(o_valve_mode);
   endproperty
   a_valve_tog: assert property (p_valve_tog) else $error("valve no toggle");
   property p_no_board;
      !i_ctrl_board ##1 !i_ctrl_board |-> !o_valve_mode;
   endproperty
   a_no_board: assert property (p_no_board) else $error("valve without board");
   property p_leg_gen;
      o_mode == 3'h1 && $past(o_mode) == 3'h1 |-> o_legends[2:0] == 3'h0;
   endproperty
   a_leg_gen: assert property (p_leg_gen) else $error("legend in general");
   property p_leg_leak;
      o_mode == 3'h2 && $past(o_mode) == 3'h2 |-> o_legends[2:0] == 3'h1;
   endproperty
   a_leg_leak: assert property (p_leg_leak) else $error("leakage legend");
   property p_leg_valve;
      o_valve_mode && $past(o_valve_mode) |-> o_legends[10:6] == 5'h1F;
   endproperty
   a_leg_valve: assert property (p_leg_valve) else $error("valve labels");
   property p_pos_load;
      o_valve_mode && i_valve_sel && i_valve_pos <= 3'h4 |=> o_valve_pos == $past(i_valve_pos);
   endproperty
   a_pos_load: assert property (p_pos_load) else $error("valve pos not loaded");
   property p_auto;
      o_valve_pos == 3'h1 && $past(o_valve_pos) == 3'h1 |-> o_auto_drive;
   endproperty
   a_auto: assert property (p_auto) else $error("auto not driven");
endmodule
bind gmdc_top gmdc_top_checker i_gmdc_top_checker (.i_clk, .i_reset_n, .i_key_view, .i_key_valve,
   .i_ctrl_board, .i_valve_sel, .i_valve_pos, .o_mode, .o_valve_mode, .o_valve_pos, .o_legends,
   .o_main_field, .o_auto_drive);
`default_nettype wire

// File: sim/tb_top.sv
// Self-checking bench for the gauge mode display controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int LT = 20;
   logic clk, rst_n, kv, kva, brd, srate, vsel, rwr, asel, vm, adrv;
   logic [2:0] vpos, mode, vp;
   logic [1:0] ridx, rch, arec, dev, ach;
   logic [15:0] rint, rsp, rld, rgn, asp, ald, agn, v, d;
   logic [63:0] pres;
   logic [11:0] st, leg;
   logic [39:0] mainf;
   logic [119:0] upf;
   logic [15:0] sp [4];
   logic [2:0] seq [7] = '{3'h2, 3'h3, 3'h4, 3'h1, 3'h2, 3'h4, 3'h1};
   logic [31:0] seed = 32'h597280B9;
   int err_count = 0;
   int num_checks = 0;
   int cyc = 0;
   gmdc_top #(.LAMP_TEST_CYCLES(LT)) i_gmdc_top (.i_clk(clk), .i_reset_n(rst_n), .i_key_view(kv),
      .i_key_valve(kva), .i_ctrl_board(brd), .i_show_rate(srate), .i_rate_interval(rint),
      .i_pressure(pres), .i_status(st), .i_valve_sel(vsel), .i_valve_pos(vpos), .i_recipe_wr(rwr),
      .i_recipe_idx(ridx), .i_recipe_setpoint(rsp), .i_recipe_lead(rld), .i_recipe_gain(rgn),
      .i_recipe_channel(rch), .i_active_sel(asel), .o_mode(mode), .o_valve_mode(vm),
      .o_valve_pos(vp), .o_active_recipe(arec), .o_legends(leg), .o_main_field(mainf),
      .o_upper_fields(upf), .o_deviation(dev), .o_auto_drive(adrv), .o_auto_setpoint(asp),
      .o_auto_lead(ald), .o_auto_gain(agn), .o_auto_channel(ach));
   gmdc_keypad_model i_gmdc_keypad_model (.i_clk(clk), .o_key_view(kv), .o_key_valve(kva));
   // ****
   // Helpers
   // ****
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [39:0] xf(input logic [2:0] s, input logic [15:0] x);
      logic [39:0] f;
      f = 40'h0;
      case (s)
         3'h0: for (int k = 0; k < 4; k++) f[k*8+:8] = {4'h0, x[k*4+:4]};
         3'h1: f[15:0] = 16'h793F;
         3'h2: f[15:0] = 16'h7906;
         3'h3: f = {5{8'h08}};
         3'h4: f = {5{8'h01}};
         3'h5: f = {5{8'h80}};
         3'h6: f = {5{8'hC0}};
         default: f = 40'h0;
      endcase
      return f;
   endfunction
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #10;
   endtask
   task automatic chk_val(input logic [63:0] got, input logic [63:0] exp, input string w);
      num_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("Error %0t: %s got %h exp %h", $time, w, got, exp);
      end
   endtask
   task automatic chk_fld(input logic [39:0] got, input logic [2:0] s, input logic [15:0] x);
      chk_val(got, xf(s, x), "field");
   endtask
   task automatic press(input bit b, input int h);
      i_gmdc_keypad_model.press(b, h);
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Run is well under this; a hang ends here
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         err_count++;
         give_verdict();
      end
   end
   // ****
   // Scenarios
   // ****
   initial
   begin
      {rst_n, srate, vsel, rwr, asel, vpos, ridx, rch, rsp, rld, rgn, pres} = '0;
      brd = 1'b1;
      rint = 16'h3;
      st = 12'hFF8;
      tick(20);
      chk_val(leg, 12'hFFF, "reset legends");
      rst_n = 1'b1;
      tick(LT - 5);
      chk_val({mode, mainf}, {3'h0, 40'hFFFFFFFFFF}, "lamp");
      tick(10);
      chk_val(mode, 3'h1, "general");
      $display("test power-up done");
      for (int i = 0; i < 7; i++)
      begin
         brd = (i < 4);
         press(0, 1 + i);
         chk_val(mode, seq[i], "mode");
         chk_val(leg[2:0], (seq[i] == 3'h2) ? 3'h1 : (seq[i] == 3'h3) ? 3'h4 : (seq[i] == 3'h4) ? 3'h2 : 3'h0, "leg");
      end
      press(1, 1);
      chk_val(vm, 1'b0, "valve no board");
      brd = 1'b1;
      press(0, 1);
      press(1, 2);
      chk_val({vm, leg[10:6], leg[0]}, 7'h7F, "valve mode");
      for (int p = 0; p < 6; p++)
      begin
         vpos = p[2:0];
         vsel = 1'b1;
         tick(1);
         vsel = 1'b0;
         tick(1);
         chk_val({vp, adrv}, (p < 5) ? {p[2:0], p == 1} : 4'h8, "pos");
      end
      press(0, 1);
      chk_val({mode, vm}, 4'h7, "view in valve");
      press(1, 1);
      chk_val(vm, 1'b0, "valve off");
      $display("test modes done");
      for (int n = 0; n < 4 && mode !== 3'h1; n++) press(0, 1);
      for (int s = 0; s < 7; s++)
      begin
         v = 16'(rnd());
         pres[15:0] = v;
         st[2:0] = s[2:0];
         tick(2);
         chk_fld(mainf, s[2:0], v);
         chk_fld(upf[39:0], s[2:0], v);
         chk_fld(upf[79:40], 3'h7, v);
         chk_val(leg[5:3], (s == 1) ? 3'h1 : (s == 3) ? 3'h2 : (s == 4) ? 3'h4 : 3'h0, "status leg");
      end
      st = 12'h1F8;
      pres[63:48] = ~v;
      tick(2);
      chk_fld(mainf, 3'h0, ~v);
      st = 12'hFF8;
      tick(2);
      press(0, 1);
      d = 16'(rnd());
      pres[15:0] = v + d;
      tick(2);
      chk_fld(mainf, 3'h0, d);
      srate = 1'b1;
      d = {8'h0, d[7:0]};
      repeat (12)
      begin
         pres[15:0] += d;
         tick(1);
      end
      chk_fld(mainf, 3'h0, 16'(d * 4));
      $display("test display done");
      rwr = 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         sp[i] = {1'b0, 15'(rnd() >> 17)} | 16'h1;
         {ridx, rsp, rld, rgn, rch} = {i[1:0], sp[i], ~sp[i], sp[i] ^ 16'h5A5A, ~i[1:0]};
         tick(1);
      end
      rwr = 1'b0;
      press(1, 1);
      ridx = 2'h2;
      asel = 1'b1;
      vpos = 3'h1;
      vsel = 1'b1;
      tick(1);
      {asel, vsel, st} = '0;
      pres = {4{sp[2] - 16'h1}};
      tick(2);
      chk_val({arec, adrv, asp, ald, agn, ach}, {3'h5, sp[2], ~sp[2], sp[2] ^ 16'h5A5A, 2'h1}, "recipe");
      chk_val({dev, leg[11]}, 3'h3, "dev below");
      pres = {4{sp[2] + 16'h1}};
      tick(2);
      chk_val(dev, 2'h2, "dev above");
      rst_n = 1'b0;
      tick(1);
      chk_val({mode, vm}, 4'h0, "reset state");
      rst_n = 1'b1;
      tick(LT + 3);
      chk_val({mode, vm, dev}, 6'h08, "after reset");
      $display("test recipes and reset done");
      give_verdict();
   end
endmodule
`default_nettype wire

// File: src/gmdc_field_fmt.sv
// Channel field formatter: status code to segment pattern
`timescale 1ns/1ps
`default_nettype none
module gmdc_field_fmt
(
   input wire logic [2:0] i_status,
   input wire logic [gmdc_pkg::PW-1:0] i_value,
   output logic [gmdc_pkg::FIELD_W-1:0] o_field
);
   // ****************************************
   // Formatting
   // ****************************************
   // Value digits are raw nibble codes; a real decoder sits in the glass driver
   wire logic [gmdc_pkg::FIELD_W-1:0] value_field;
   assign value_field = {8'h00, 4'h0, i_value[15:12], 4'h0, i_value[11:8], 4'h0, i_value[7:4], 4'h0, i_value[3:0]};

   always_comb
   begin
      case (i_status)
         gmdc_pkg::ST_NO_SENSOR: o_field = {{3{gmdc_pkg::SEG_BLANK}}, gmdc_pkg::SEG_E, gmdc_pkg::SEG_ZERO};
         gmdc_pkg::ST_BAD: o_field = {{3{gmdc_pkg::SEG_BLANK}}, gmdc_pkg::SEG_E, gmdc_pkg::SEG_ONE};
         gmdc_pkg::ST_UNDER: o_field = {gmdc_pkg::DIGITS{gmdc_pkg::SEG_LOWER}};
         gmdc_pkg::ST_OVER: o_field = {gmdc_pkg::DIGITS{gmdc_pkg::SEG_UPPER}};
         gmdc_pkg::ST_USER_OFF: o_field = {gmdc_pkg::DIGITS{gmdc_pkg::SEG_DP}};
         gmdc_pkg::ST_AUTO_OFF: o_field = {gmdc_pkg::DIGITS{gmdc_pkg::SEG_DASH_DP}};
         gmdc_pkg::ST_ABSENT: o_field = {gmdc_pkg::DIGITS{gmdc_pkg::SEG_BLANK}};
         default: o_field = value_field;
      endcase
   end
endmodule
`default_nettype wire

// File: src/gmdc_pkg.sv
// Package with mode, status, timing and display constants for the gauge mode display controller
package gmdc_pkg;
   // ****************************************
   // Sizes
   // ****************************************
   localparam int NUM_CH = 4;
   localparam int PW = 16;
   localparam int NUM_RECIPE = 4;
   localparam int RIDX_W = 2;
   localparam int CH_W = 2;
   localparam int DIGITS = 5;
   localparam int SEG_W = 8;
   localparam int FIELD_W = DIGITS * SEG_W;
   localparam int RATE_W = 16;

   // ****************************************
   // Timing
   // ****************************************
   localparam longint CLK_HZ = 10000000;
   localparam longint LAMP_TEST_MS = 5000;
   localparam longint LAMP_TEST_CYCLES = (CLK_HZ * LAMP_TEST_MS) / 1000;

   // ****************************************
   // Modes
   // ****************************************
   typedef enum logic [2:0] {
      GMDC_POWERUP,
      GMDC_GENERAL,
      GMDC_LEAKAGE,
      GMDC_TUNING,
      GMDC_SETUP
   } gmdc_mode_t;

   typedef enum logic [2:0] {
      GMDC_VALVE_OPEN,
      GMDC_VALVE_AUTO,
      GMDC_VALVE_CLOSE,
      GMDC_VALVE_HOLD,
      GMDC_VALVE_MANUAL
   } gmdc_valve_t;

   // Channel status codes from the sensor side
   localparam logic [2:0] ST_OK = 3'h0;
   localparam logic [2:0] ST_NO_SENSOR = 3'h1;
   localparam logic [2:0] ST_BAD = 3'h2;
   localparam logic [2:0] ST_UNDER = 3'h3;
   localparam logic [2:0] ST_OVER = 3'h4;
   localparam logic [2:0] ST_USER_OFF = 3'h5;
   localparam logic [2:0] ST_AUTO_OFF = 3'h6;
   localparam logic [2:0] ST_ABSENT = 3'h7;

   // ****************************************
   // Segment patterns per digit (bit 7 is decimal point, 6..0 = g..a)
   // ****************************************
   localparam logic [SEG_W-1:0] SEG_BLANK = 8'h00;
   localparam logic [SEG_W-1:0] SEG_ALL = 8'hFF;
   localparam logic [SEG_W-1:0] SEG_E = 8'h79;
   localparam logic [SEG_W-1:0] SEG_ZERO = 8'h3F;
   localparam logic [SEG_W-1:0] SEG_ONE = 8'h06;
   localparam logic [SEG_W-1:0] SEG_LOWER = 8'h08;
   localparam logic [SEG_W-1:0] SEG_UPPER = 8'h01;
   localparam logic [SEG_W-1:0] SEG_DP = 8'h80;
   localparam logic [SEG_W-1:0] SEG_DASH_DP = 8'hC0;

   // Legend bit positions
   localparam int LEG_W = 12;
   localparam int LEG_LEAKAGE = 0;
   localparam int LEG_SETUP = 1;
   localparam int LEG_TUNING = 2;
   localparam int LEG_NO_SENSOR = 3;
   localparam int LEG_UNDER = 4;
   localparam int LEG_OVER = 5;
   localparam int LEG_OPEN = 6;
   localparam int LEG_AUTO = 7;
   localparam int LEG_CLOSE = 8;
   localparam int LEG_HOLD = 9;
   localparam int LEG_MANUAL = 10;
   localparam int LEG_DEVIATION = 11;
endpackage

// File: src/gmdc_recipe_store.sv
// Four-entry recipe memory with active recipe selection
`timescale 1ns/1ps
`default_nettype none
module gmdc_recipe_store
(
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_wr,
   input wire logic [gmdc_pkg::RIDX_W-1:0] i_wr_idx,
   input wire logic [gmdc_pkg::PW-1:0] i_wr_setpoint,
   input wire logic [gmdc_pkg::PW-1:0] i_wr_lead,
   input wire logic [gmdc_pkg::PW-1:0] i_wr_gain,
   input wire logic [gmdc_pkg::CH_W-1:0] i_wr_channel,
   input wire logic [gmdc_pkg::RIDX_W-1:0] i_active_idx,
   output logic [gmdc_pkg::PW-1:0] o_setpoint,
   output logic [gmdc_pkg::PW-1:0] o_lead,
   output logic [gmdc_pkg::PW-1:0] o_gain,
   output logic [gmdc_pkg::CH_W-1:0] o_channel
);
   // ****************************************
   // Storage
   // ****************************************
   logic [gmdc_pkg::PW-1:0] setpoint_ff [gmdc_pkg::NUM_RECIPE];
   logic [gmdc_pkg::PW-1:0] lead_ff [gmdc_pkg::NUM_RECIPE];
   logic [gmdc_pkg::PW-1:0] gain_ff [gmdc_pkg::NUM_RECIPE];
   logic [gmdc_pkg::CH_W-1:0] chan_ff [gmdc_pkg::NUM_RECIPE];

   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         for (int i = 0; i < gmdc_pkg::NUM_RECIPE; i++)
         begin
            setpoint_ff[i] <= '0;
            lead_ff[i] <= '0;
            gain_ff[i] <= '0;
            chan_ff[i] <= '0;
         end
      end
      else if (i_wr)
      begin
         setpoint_ff[i_wr_idx] <= i_wr_setpoint;
         lead_ff[i_wr_idx] <= i_wr_lead;
         gain_ff[i_wr_idx] <= i_wr_gain;
         chan_ff[i_wr_idx] <= i_wr_channel;
      end
   end

   // Only the active entry reaches the loop
   assign o_setpoint = setpoint_ff[i_active_idx];
   assign o_lead = lead_ff[i_active_idx];
   assign o_gain = gain_ff[i_active_idx];
   assign o_channel = chan_ff[i_active_idx];
endmodule
`default_nettype wire

// File: src/gmdc_top.sv
// Gauge mode state machine, leakage math, channel fields and valve control
`timescale 1ns/1ps
`default_nettype none
module gmdc_top
#(
   parameter longint LAMP_TEST_CYCLES = gmdc_pkg::LAMP_TEST_CYCLES
)
(
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_key_view,
   input wire logic i_key_valve,
   input wire logic i_ctrl_board,
   input wire logic i_show_rate,
   input wire logic [gmdc_pkg::RATE_W-1:0] i_rate_interval,
   input wire logic [gmdc_pkg::NUM_CH*gmdc_pkg::PW-1:0] i_pressure,
   input wire logic [gmdc_pkg::NUM_CH*3-1:0] i_status,
   input wire logic i_valve_sel,
   input wire logic [2:0] i_valve_pos,
   input wire logic i_recipe_wr,
   input wire logic [gmdc_pkg::RIDX_W-1:0] i_recipe_idx,
   input wire logic [gmdc_pkg::PW-1:0] i_recipe_setpoint,
   input wire logic [gmdc_pkg::PW-1:0] i_recipe_lead,
   input wire logic [gmdc_pkg::PW-1:0] i_recipe_gain,
   input wire logic [gmdc_pkg::CH_W-1:0] i_recipe_channel,
   input wire logic i_active_sel,
   output logic [2:0] o_mode,
   output logic o_valve_mode,
   output logic [2:0] o_valve_pos,
   output logic [gmdc_pkg::RIDX_W-1:0] o_active_recipe,
   output logic [gmdc_pkg::LEG_W-1:0] o_legends,
   output logic [gmdc_pkg::FIELD_W-1:0] o_main_field,
   output logic [3*gmdc_pkg::FIELD_W-1:0] o_upper_fields,
   output logic [1:0] o_deviation,
   output logic o_auto_drive,
   output logic [gmdc_pkg::PW-1:0] o_auto_setpoint,
   output logic [gmdc_pkg::PW-1:0] o_auto_lead,
   output logic [gmdc_pkg::PW-1:0] o_auto_gain,
   output logic [gmdc_pkg::CH_W-1:0] o_auto_channel
);
   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [gmdc_pkg::PW-1:0] ch_p(input logic [gmdc_pkg::NUM_CH*gmdc_pkg::PW-1:0] v,
                                                  input int c);
      ch_p = v[c*gmdc_pkg::PW +: gmdc_pkg::PW];
   endfunction

   function automatic logic [2:0] ch_s(input logic [gmdc_pkg::NUM_CH*3-1:0] v, input int c);
      ch_s = v[c*3 +: 3];
   endfunction

   // ****************************************
   // Mode state machine
   // ****************************************
   gmdc_pkg::gmdc_mode_t mode_ff, nxt_mode;
   logic valve_ff, nxt_valve;
   logic [31:0] test_cnt_ff;
   logic key_view_d_ff, key_valve_d_ff;
   wire logic view_press;
   wire logic valve_press;
   wire logic test_done;
   // Edge detect so a held key counts once
   assign view_press = i_key_view && !key_view_d_ff;
   assign valve_press = i_key_valve && !key_valve_d_ff;
   assign test_done = (test_cnt_ff == 32'(LAMP_TEST_CYCLES - 1));
   always_comb
   begin
      nxt_mode = mode_ff;
      nxt_valve = valve_ff;
      case (mode_ff)
         gmdc_pkg::GMDC_POWERUP:
            if (test_done)
               nxt_mode = gmdc_pkg::GMDC_GENERAL;
         gmdc_pkg::GMDC_GENERAL:
            if (view_press)
               nxt_mode = gmdc_pkg::GMDC_LEAKAGE;
         gmdc_pkg::GMDC_LEAKAGE:
            if (view_press)
               nxt_mode = i_ctrl_board ? gmdc_pkg::GMDC_TUNING : gmdc_pkg::GMDC_SETUP;
         gmdc_pkg::GMDC_TUNING:
            if (view_press)
               nxt_mode = gmdc_pkg::GMDC_SETUP;
         gmdc_pkg::GMDC_SETUP:
            if (view_press)
               nxt_mode = gmdc_pkg::GMDC_GENERAL;
         default: nxt_mode = gmdc_pkg::GMDC_GENERAL;
      endcase
      if (mode_ff != gmdc_pkg::GMDC_POWERUP && valve_press && i_ctrl_board)
         nxt_valve = !valve_ff;
      if (!i_ctrl_board)
         nxt_valve = 1'b0;
   end

   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         mode_ff <= gmdc_pkg::GMDC_POWERUP;
         valve_ff <= 1'b0;
         test_cnt_ff <= '0;
         key_view_d_ff <= 1'b0;
         key_valve_d_ff <= 1'b0;
      end
      else
      begin
         mode_ff <= nxt_mode;
         valve_ff <= nxt_valve;
         test_cnt_ff <= (mode_ff == gmdc_pkg::GMDC_POWERUP) ? test_cnt_ff + 32'h1 : '0;
         key_view_d_ff <= i_key_view;
         key_valve_d_ff <= i_key_valve;
      end
   end

   wire logic in_test;
   wire logic enter_leak;
   assign in_test = (mode_ff == gmdc_pkg::GMDC_POWERUP);
   assign enter_leak = (nxt_mode == gmdc_pkg::GMDC_LEAKAGE) && (mode_ff != gmdc_pkg::GMDC_LEAKAGE);

   // ****************************************
   // Leakage base and rate
   // ****************************************
   logic [gmdc_pkg::PW-1:0] base_ff [gmdc_pkg::NUM_CH];
   logic [gmdc_pkg::PW-1:0] rate_ref_ff [gmdc_pkg::NUM_CH];
   logic [gmdc_pkg::PW-1:0] rate_ff [gmdc_pkg::NUM_CH];
   logic [gmdc_pkg::RATE_W-1:0] rate_cnt_ff;
   wire logic rate_tick;
   // Interval of zero behaves as one cycle rather than stalling
   assign rate_tick = (rate_cnt_ff >= i_rate_interval);

   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         rate_cnt_ff <= '0;
         for (int c = 0; c < gmdc_pkg::NUM_CH; c++)
         begin
            base_ff[c] <= '0;
            rate_ref_ff[c] <= '0;
            rate_ff[c] <= '0;
         end
      end
      else
      begin
         rate_cnt_ff <= (rate_tick || enter_leak) ? '0 : rate_cnt_ff + 16'h1;
         for (int c = 0; c < gmdc_pkg::NUM_CH; c++)
         begin
            if (enter_leak)
            begin
               base_ff[c] <= ch_p(i_pressure, c);
               rate_ref_ff[c] <= ch_p(i_pressure, c);
               rate_ff[c] <= '0;
            end
            else if (rate_tick)
            begin
               rate_ff[c] <= ch_p(i_pressure, c) - rate_ref_ff[c];
               rate_ref_ff[c] <= ch_p(i_pressure, c);
            end
         end
      end
   end

   // ****************************************
   // Channel fields
   // ****************************************
   wire logic all_used;
   wire logic [1:0] main_ch;
   wire logic is_leak;
   wire logic [gmdc_pkg::PW-1:0] leak_now;
   wire logic [gmdc_pkg::PW-1:0] main_val;
   wire logic [gmdc_pkg::FIELD_W-1:0] main_fmt;
   wire logic [3*gmdc_pkg::FIELD_W-1:0] upper_fmt;
   assign all_used = (ch_s(i_status, 3) != gmdc_pkg::ST_ABSENT);
   assign main_ch = all_used ? 2'h3 : 2'h0;
   assign is_leak = (mode_ff == gmdc_pkg::GMDC_LEAKAGE);
   assign leak_now = ch_p(i_pressure, int'(main_ch)) - base_ff[main_ch];
   assign main_val = !is_leak ? ch_p(i_pressure, int'(main_ch)) : (i_show_rate ? rate_ff[main_ch] : leak_now);
   gmdc_field_fmt u_main_fmt
   (
      .i_status(ch_s(i_status, int'(main_ch))),
      .i_value(main_val),
      .o_field(main_fmt)
   );
   // Upper fields show channels 1..3; channel 4 only ever appears in main
   genvar g;
   generate
      for (g = 0; g < 3; g++)
      begin : g_upper
         gmdc_field_fmt u_fmt
         (
            .i_status(i_status[g*3 +: 3]),
            .i_value(i_pressure[g*gmdc_pkg::PW +: gmdc_pkg::PW]),
            .o_field(upper_fmt[g*gmdc_pkg::FIELD_W +: gmdc_pkg::FIELD_W])
         );
      end
   endgenerate

   // ****************************************
   // Legends
   // ****************************************
   logic [gmdc_pkg::LEG_W-1:0] legends;
   logic no_sensor_any, under_any, over_any;
   always_comb
   begin
      no_sensor_any = 1'b0;
      under_any = 1'b0;
      over_any = 1'b0;
      for (int c = 0; c < gmdc_pkg::NUM_CH; c++)
      begin
         no_sensor_any |= (ch_s(i_status, c) == gmdc_pkg::ST_NO_SENSOR);
         under_any |= (ch_s(i_status, c) == gmdc_pkg::ST_UNDER);
         over_any |= (ch_s(i_status, c) == gmdc_pkg::ST_OVER);
      end
      legends = '0;
      legends[gmdc_pkg::LEG_LEAKAGE] = is_leak;
      legends[gmdc_pkg::LEG_SETUP] = (mode_ff == gmdc_pkg::GMDC_SETUP);
      legends[gmdc_pkg::LEG_TUNING] = (mode_ff == gmdc_pkg::GMDC_TUNING);
      legends[gmdc_pkg::LEG_NO_SENSOR] = no_sensor_any;
      legends[gmdc_pkg::LEG_UNDER] = under_any;
      legends[gmdc_pkg::LEG_OVER] = over_any;
      legends[gmdc_pkg::LEG_OPEN] = valve_ff;
      legends[gmdc_pkg::LEG_AUTO] = valve_ff;
      legends[gmdc_pkg::LEG_CLOSE] = valve_ff;
      legends[gmdc_pkg::LEG_HOLD] = valve_ff;
      legends[gmdc_pkg::LEG_MANUAL] = valve_ff;
      legends[gmdc_pkg::LEG_DEVIATION] = valve_ff || (mode_ff == gmdc_pkg::GMDC_TUNING);
   end

   // ****************************************
   // Valve position and recipes
   // ****************************************
   gmdc_pkg::gmdc_valve_t valve_pos_ff;
   logic [gmdc_pkg::RIDX_W-1:0] active_ff;
   wire logic [gmdc_pkg::PW-1:0] rc_setpoint;
   wire logic [gmdc_pkg::PW-1:0] rc_lead;
   wire logic [gmdc_pkg::PW-1:0] rc_gain;
   wire logic [gmdc_pkg::CH_W-1:0] rc_channel;
   wire logic pos_ok;
   assign pos_ok = (i_valve_pos <= 3'(gmdc_pkg::GMDC_VALVE_MANUAL));
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         valve_pos_ff <= gmdc_pkg::GMDC_VALVE_HOLD;
         active_ff <= '0;
      end
      else if (valve_ff)
      begin
         if (i_valve_sel && pos_ok)
            valve_pos_ff <= gmdc_pkg::gmdc_valve_t'(i_valve_pos);
         if (i_active_sel)
            active_ff <= i_recipe_idx;
      end
   end
   gmdc_recipe_store u_recipes
   (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_wr(i_recipe_wr),
      .i_wr_idx(i_recipe_idx),
      .i_wr_setpoint(i_recipe_setpoint),
      .i_wr_lead(i_recipe_lead),
      .i_wr_gain(i_recipe_gain),
      .i_wr_channel(i_recipe_channel),
      .i_active_idx(active_ff),
      .o_setpoint(rc_setpoint),
      .o_lead(rc_lead),
      .o_gain(rc_gain),
      .o_channel(rc_channel)
   );

   // Deviation: 01 below, 10 above, 11 equal to set point
   wire logic [gmdc_pkg::PW-1:0] ctl_p;
   wire logic [1:0] dev;
   assign ctl_p = ch_p(i_pressure, int'(rc_channel));
   assign dev = (ctl_p < rc_setpoint) ? 2'h1 : ((ctl_p > rc_setpoint) ? 2'h2 : 2'h3);

   // ****************************************
   // Registered outputs
   // ****************************************
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         o_legends <= '1;
         o_main_field <= '1;
         o_upper_fields <= '1;
         o_deviation <= '0;
         o_auto_drive <= 1'b0;
         o_auto_setpoint <= '0;
         o_auto_lead <= '0;
         o_auto_gain <= '0;
         o_auto_channel <= '0;
      end
      else
      begin
         o_legends <= in_test ? '1 : legends;
         o_main_field <= in_test ? '1 : main_fmt;
         o_upper_fields <= in_test ? '1 : upper_fmt;
         o_deviation <= (valve_ff || mode_ff == gmdc_pkg::GMDC_TUNING) ? dev : 2'h0;
         o_auto_drive <= (valve_pos_ff == gmdc_pkg::GMDC_VALVE_AUTO);
         o_auto_setpoint <= rc_setpoint;
         o_auto_lead <= rc_lead;
         o_auto_gain <= rc_gain;
         o_auto_channel <= rc_channel;
      end
   end

   assign o_mode = 3'(mode_ff);
   assign o_valve_mode = valve_ff;
   assign o_valve_pos = 3'(valve_pos_ff);
   assign o_active_recipe = active_ff;
endmodule
`default_nettype wire
